// ==== src/emfp_printer.sv ====
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ns
// Overview of operation
// R1: each error frame is exactly four 16-bit words.
// R2: word one: job number 4 in bits 15..12, text number below.
// R3: job 4 texts are printed with no line feed.
// R4: I/O errors use texts 3851-3853, I/O timeout uses 3854.
// R5: texts 3841-3845 cover processor, interface, memory, firmware, battery faults.
// R6: texts 3847-3850 and 3855 cover restart, power, stop, handling, unassigned.
// R7: words two to four are decoded by the text number.
// R8: I/O error: word2 word/bit, word3 group plus 3888, word4 program/error.
// R9: timeout word2 is module type 3872 to 3876.
// R10: timeout word3 is 255 or word number, word4 program/error.
// R11: LAN error text 3846, slave, 41h or 42h, zero word.
// R12: other errors: word2 word/bit, word3 zero, word4 program/error.
// R13: look up text, print it with the parameter words inserted.
// R14: printer link 9600 baud, 7 data bits, even parity, no handshake.
// R15: carriage return code 0Ah, line feed code 0Dh.
// R16: frame read only after all four words written, then memory refreshed.
// R17: transfer memory is eight consecutive bytes at offsets 0 to 7.
// R18: bad job number or unknown text: frame dropped, printer untouched.
module emfp_printer
  import emfp_pkg::*;
#(
  parameter int BIT_CYCLES = EMFP_BIT_CYCLES  // cycles per serial bit
)
(
  input wire logic pclk,            // system clock
  input wire logic presetn,         // async reset, active low
  input wire logic psel,            // apb select
  input wire logic penable,         // apb access phase
  input wire logic pwrite,          // apb direction
  input wire logic [7:0] paddr,     // apb byte address
  input wire logic [31:0] pwdata,   // apb write data
  output logic [31:0] prdata,       // apb read data
  output logic pready,              // apb ready
  output logic pslverr,             // apb error, unmapped address
  output logic irq,                 // level interrupt
  output logic txd                  // serial line to printer, idles high
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] xfer [8];
  logic [7:0] written;
  logic ctrl_en;
  logic [1:0] stat_ev;
  logic [1:0] irq_mask;
  logic [15:0] printed_cnt;
  emfp_frame_t frame;
  emfp_state_t state;
  logic [5:0] pos;
  logic tx_start;
  logic tx_busy;
  logic [9:0] tx_shift;
  logic [3:0] tx_left;
  logic [31:0] tx_cnt;
  logic ev_done;
  logic ev_rej;
  logic take_frame;
  logic apb_access;
  logic apb_wr;
  logic xfer_hit;
  logic [2:0] xfer_idx;
  logic mapped;
  logic [31:0] next_rdata;
  logic [7:0] cur_char;
  logic frame_ok;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // ascii hex digit of a nibble
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    if (n < 4'hA)
      hex_char = 8'h30 + {4'h0, n};
    else
      hex_char = 8'h37 + {4'h0, n};
  endfunction

  // stored texts, sixteen characters each; index is text number minus 3841
  function automatic logic [7:0] text_char(input logic [3:0] idx, input logic [3:0] p);
    logic [127:0] s;
    s = "CANNOT EVALUATE ";
    unique case (idx)
      4'h0: s = "CPU ERROR       ";  // see R5
      4'h1: s = "CPU/IF ERROR    ";
      4'h2: s = "USER MEM ERROR  ";
      4'h3: s = "FW EPROM ERROR  ";
      4'h4: s = "BATTERY FAULT   ";
      4'h5: s = "LAN ERROR       ";  // see R11
      4'h6: s = "WARM RESTART ERR";  // see R6
      4'h7: s = "POWER OFF       ";
      4'h8: s = "STOP SWITCHED   ";
      4'h9: s = "HANDLING ERROR  ";
      4'hA: s = "I/O ERROR DIG IN";  // see R4
      4'hB: s = "I/O ERROR DQ    ";
      4'hC: s = "I/O ERROR ANALOG";
      4'hD: s = "TIMEOUT         ";
      4'hE: s = "CANNOT EVALUATE ";
      4'hF: s = "CANNOT EVALUATE ";
    endcase
    text_char = s[{4'(4'hF - p), 3'h0} +: 8];
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // one wait state: pready rises on the second access cycle
  assign apb_access = psel & penable & ~pready;
  assign apb_wr = psel & penable & pready & pwrite;
  assign xfer_hit = (paddr[7:2] <= EMFP_XFER_LAST_IDX[5:0]) && (paddr[1:0] == 2'h0);  // see R17
  assign xfer_idx = paddr[4:2];
  assign mapped = xfer_hit || paddr == EMFP_CTRL_ADDR || paddr == EMFP_STAT_ADDR
    || paddr == EMFP_MASK_ADDR || paddr == EMFP_INFO_ADDR;

  // read mux, reserved bits read as zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (xfer_hit)
      next_rdata = {24'h00_0000, xfer[xfer_idx]};
    else if (paddr == EMFP_CTRL_ADDR)
      next_rdata[EMFP_CTRL_EN_BIT] = ctrl_en;
    else if (paddr == EMFP_STAT_ADDR)
    begin
      next_rdata[1:0] = stat_ev;
      next_rdata[EMFP_BUSY_BIT] = (state != EMFP_ST_IDLE);
    end
    else if (paddr == EMFP_MASK_ADDR)
      next_rdata[1:0] = irq_mask;
    else if (paddr == EMFP_INFO_ADDR)
      next_rdata[15:0] = printed_cnt;
  end

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= apb_access;
      pslverr <= apb_access & ~mapped;
      if (apb_access && !pwrite)
        prdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // transfer memory
  // ----------------------------------------------------------------
  // frame taken only once all eight bytes, four words, are written
  assign take_frame = (state == EMFP_ST_IDLE) && ctrl_en && (written == 8'hFF);  // see R16

  // hardware refresh first, so a write in the same cycle still lands
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
        xfer[i] <= 8'h00;
      written <= 8'h00;
    end
    else
    begin
      if (take_frame)
      begin
        // refresh with current data: echoed word one and print count
        xfer[0] <= xfer[0];  // see R16
        xfer[1] <= xfer[1];
        xfer[2] <= printed_cnt[15:8];
        xfer[3] <= printed_cnt[7:0];
        xfer[4] <= 8'h00;
        xfer[5] <= 8'h00;
        xfer[6] <= 8'h00;
        xfer[7] <= 8'h00;
        written <= 8'h00;
      end
      if (apb_wr && xfer_hit)
      begin
        xfer[xfer_idx] <= pwdata[7:0];
        written[xfer_idx] <= 1'b1;  // see R1
      end
    end
  end

  // frame latch, high byte of each word at the even offset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame <= '0;
    else if (take_frame)
      frame <= {xfer[0], xfer[1], xfer[2], xfer[3], xfer[4], xfer[5], xfer[6], xfer[7]};
  end

  // ----------------------------------------------------------------
  // control, status, interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_en <= EMFP_CTRL_RESET;
      irq_mask <= EMFP_MASK_RESET;
    end
    else if (apb_wr)
    begin
      if (paddr == EMFP_CTRL_ADDR)
        ctrl_en <= pwdata[EMFP_CTRL_EN_BIT];
      if (paddr == EMFP_MASK_ADDR)
        irq_mask <= pwdata[1:0];
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_ev <= 2'h0;
    else
    begin
      if (apb_wr && paddr == EMFP_STAT_ADDR)
        stat_ev <= stat_ev & ~pwdata[1:0];
      if (ev_done)
        stat_ev[EMFP_EV_DONE_BIT] <= 1'b1;
      if (ev_rej)
        stat_ev[EMFP_EV_REJ_BIT] <= 1'b1;
    end
  end

  // registered interrupt level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(stat_ev & irq_mask);
  end

  // ----------------------------------------------------------------
  // frame check and line sequencer
  // ----------------------------------------------------------------
  // job field must be 4 and the text must have a stored entry
  assign frame_ok = (frame.w1[15:12] == EMFP_JOB_NUMBER)  // see R2
    && (frame.w1[11:0] >= EMFP_TEXT_FIRST)
    && (frame.w1[11:0] <= EMFP_TEXT_LAST);  // see R18

  // character at the current line position
  always_comb
  begin
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [15:0] t;
    logic [3:0] p;
    a = frame.w2[15:8];
    b = frame.w2[7:0];
    c = 8'h00;
    t = 16'h0000;
    p = pos[3:0];
    // parameter meaning follows the text number
    if (frame.w1[11:0] == EMFP_TEXT_TIMEOUT)  // see R7
    begin
      t = frame.w2 - EMFP_MODTYPE_BASE;  // see R9
      a = t[7:0];
      b = frame.w3[7:0];  // see R10
    end
    else if (frame.w1[11:0] == EMFP_TEXT_LAN)
    begin
      a = frame.w2[15:8];  // see R11
      b = frame.w2[7:0];
      c = frame.w3[7:0];
    end
    else if (frame.w1[11:0] >= EMFP_TEXT_IO_FIRST && frame.w1[11:0] <= EMFP_TEXT_IO_LAST)
    begin
      t = frame.w3 - EMFP_GROUP_BASE;  // see R8
      c = t[7:0];
    end
    else
      c = frame.w3[7:0];  // see R12
    cur_char = EMFP_SPACE;
    if (pos < EMFP_TEXT_CHARS)
      cur_char = text_char(4'(frame.w1[11:0] - EMFP_TEXT_FIRST), p);  // see R13
    else if (pos == EMFP_LINE_LAST)
      cur_char = EMFP_CR_CODE;  // see R3, R15
    else
    begin
      unique case (p)
        4'h1: cur_char = hex_char(a[7:4]);
        4'h2: cur_char = hex_char(a[3:0]);
        4'h3: cur_char = EMFP_COMMA;
        4'h4: cur_char = hex_char(b[7:4]);
        4'h5: cur_char = hex_char(b[3:0]);
        4'h7: cur_char = hex_char(c[7:4]);
        4'h8: cur_char = hex_char(c[3:0]);
        4'hA: cur_char = hex_char(frame.w4[15:12]);
        4'hB: cur_char = hex_char(frame.w4[11:8]);
        4'hC: cur_char = EMFP_COMMA;
        4'hD: cur_char = hex_char(frame.w4[7:4]);
        4'hE: cur_char = hex_char(frame.w4[3:0]);
        default: cur_char = EMFP_SPACE;
      endcase
    end
  end

  // line sequencer: one character per idle transmitter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= EMFP_ST_IDLE;
      pos <= 6'h00;
      tx_start <= 1'b0;
      ev_done <= 1'b0;
      ev_rej <= 1'b0;
      printed_cnt <= 16'h0000;
    end
    else
    begin
      tx_start <= 1'b0;
      ev_done <= 1'b0;
      ev_rej <= 1'b0;
      unique case (state)
        EMFP_ST_IDLE:
          if (take_frame)
            state <= EMFP_ST_CHECK;
        EMFP_ST_CHECK:
          if (frame_ok)
          begin
            pos <= 6'h00;
            state <= EMFP_ST_SEND;
          end
          else
          begin
            ev_rej <= 1'b1;  // see R18
            state <= EMFP_ST_IDLE;
          end
        EMFP_ST_SEND:
          if (tx_start)
            pos <= pos + 6'h01;  // advance only once the transmitter took this char
          else if (!tx_busy)
          begin
            tx_start <= 1'b1;
            if (pos == EMFP_LINE_LAST)
              state <= EMFP_ST_DRAIN;
          end
        EMFP_ST_DRAIN:
          if (!tx_busy && !tx_start)
          begin
            ev_done <= 1'b1;
            printed_cnt <= printed_cnt + 16'h0001;
            state <= EMFP_ST_IDLE;
          end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial transmitter
  // ----------------------------------------------------------------
  // no busy input and no xon/xoff: the printer can never stall us
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_busy <= 1'b0;
      tx_shift <= 10'h3FF;
      tx_left <= 4'h0;
      tx_cnt <= 32'h0000_0000;
      txd <= 1'b1;
    end
    else if (tx_start)
    begin
      // stop, even parity, seven data bits, start; lsb first
      tx_shift <= {1'b1, ^cur_char[6:0], cur_char[6:0], 1'b0};  // see R14
      tx_left <= EMFP_FRAME_BITS;
      tx_cnt <= 32'h0000_0000;
      tx_busy <= 1'b1;
    end
    else if (tx_busy)
    begin
      if (tx_cnt == 32'h0000_0000)
      begin
        if (tx_left == 4'h0)
          tx_busy <= 1'b0;
        else
        begin
          txd <= tx_shift[0];
          tx_shift <= {1'b1, tx_shift[9:1]};
          tx_left <= tx_left - 4'h1;
          tx_cnt <= 32'(BIT_CYCLES - 1);
        end
      end
      else
        tx_cnt <= tx_cnt - 32'h0000_0001;
    end
    else
      txd <= 1'b1;
  end

endmodule // emfp_printer

// ==== src/emfp_pkg.sv ====
package emfp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] EMFP_XFER_LAST_IDX = 8'h07;  // transfer bytes sit at index 0..7
  localparam logic [7:0] EMFP_CTRL_ADDR = 8'h20;
  localparam logic [7:0] EMFP_STAT_ADDR = 8'h24;
  localparam logic [7:0] EMFP_MASK_ADDR = 8'h28;
  localparam logic [7:0] EMFP_INFO_ADDR = 8'h2C;

  // control and status field positions
  localparam int EMFP_CTRL_EN_BIT = 0;
  localparam int EMFP_EV_DONE_BIT = 0;
  localparam int EMFP_EV_REJ_BIT = 1;
  localparam int EMFP_BUSY_BIT = 8;
  localparam logic EMFP_CTRL_RESET = 1'b1;
  localparam logic [1:0] EMFP_MASK_RESET = 2'h0;

  // ----------------------------------------------------------------
  // frame fields
  // ----------------------------------------------------------------
  localparam logic [3:0] EMFP_JOB_NUMBER = 4'h4;
  localparam logic [11:0] EMFP_TEXT_FIRST = 12'hF01;    // 3841
  localparam logic [11:0] EMFP_TEXT_LAN = 12'hF06;      // 3846
  localparam logic [11:0] EMFP_TEXT_IO_FIRST = 12'hF0B; // 3851
  localparam logic [11:0] EMFP_TEXT_IO_LAST = 12'hF0D;  // 3853
  localparam logic [11:0] EMFP_TEXT_TIMEOUT = 12'hF0E;  // 3854
  localparam logic [11:0] EMFP_TEXT_LAST = 12'hF0F;     // 3855
  localparam logic [15:0] EMFP_GROUP_BASE = 16'h0F30;   // 3888
  localparam logic [15:0] EMFP_MODTYPE_BASE = 16'h0F20; // 3872

  // ----------------------------------------------------------------
  // printer link
  // ----------------------------------------------------------------
  localparam int EMFP_CLK_HZ = 100_000_000;
  localparam int EMFP_BAUD = 9600;
  localparam int EMFP_BIT_CYCLES = EMFP_CLK_HZ / EMFP_BAUD;  // rounds down
  localparam logic [7:0] EMFP_CR_CODE = 8'h0A;
  localparam logic [7:0] EMFP_LF_CODE = 8'h0D;
  localparam logic [7:0] EMFP_SPACE = 8'h20;
  localparam logic [7:0] EMFP_COMMA = 8'h2C;
  localparam logic [5:0] EMFP_TEXT_CHARS = 6'h10;
  localparam logic [5:0] EMFP_LINE_LAST = 6'h20;     // position of the end code
  localparam logic [3:0] EMFP_FRAME_BITS = 4'hA;     // start, 7 data, parity, stop

  typedef struct packed {
    logic [15:0] w1;  // job and text number
    logic [15:0] w2;
    logic [15:0] w3;
    logic [15:0] w4;
  } emfp_frame_t;

  typedef enum {EMFP_ST_IDLE, EMFP_ST_CHECK, EMFP_ST_SEND, EMFP_ST_DRAIN} emfp_state_t;

endpackage

// ==== bench/emfp_printer_model.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// printer receiver on the serial line
// ----------------------------------------
module emfp_printer_model
#(
  parameter int BIT_CYCLES = 4  // cycles per serial bit
)
(
  input wire logic pclk,  // system clock
  input wire logic txd,  // serial line from block
  output logic [7:0] rx_char,  // last character
  output logic rx_stb,  // one cycle per character
  output logic rx_bad  // framing or parity fault
);
  logic [9:0] sh;
  initial
  begin
    rx_stb = 1'b0;
    rx_bad = 1'b0;
    rx_char = 8'h00;
  end
  // mid-bit sampling; nothing sent back, no busy line
  always
  begin
    @(negedge txd);
    repeat (BIT_CYCLES / 2) @(posedge pclk);
    for (int i = 0; i < 10; i++)
    begin
      sh[i] = txd;
      if (i < 9)
        repeat (BIT_CYCLES) @(posedge pclk);
    end
    rx_char <= {1'b0, sh[7:1]};
    rx_bad <= sh[0] | ~sh[9] | (^sh[8:1]);
    rx_stb <= 1'b1;
    @(posedge pclk);
    rx_stb <= 1'b0;
  end
endmodule // emfp_printer_model

// ==== bench/emfp_printer_assertions.sv ====
`timescale 1ns/1ns
module emfp_printer_assertions
  import emfp_pkg::*;
#(
  parameter int BIT_CYCLES = EMFP_BIT_CYCLES  // cycles per serial bit
)
(
  input wire logic pclk,  // clock
  input wire logic presetn,  // reset, active low
  input wire logic psel,  // select
  input wire logic penable,  // access
  input wire logic pwrite,  // direction
  input wire logic [7:0] paddr,  // address
  input wire logic [31:0] pwdata,  // write data
  input wire logic [31:0] prdata,  // read data
  input wire logic pready,  // ready
  input wire logic pslverr,  // error
  input wire logic irq,  // interrupt
  input wire logic txd  // serial out
);
  logic [15:0] run;
  logic txd_q;
  logic mapped;
  // all aligned words up to the info register are decoded
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= EMFP_INFO_ADDR);
  // cycles since txd last moved, saturating so idle never wraps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run <= 16'h0000;
      txd_q <= 1'b1;
    end
    else
    begin
      txd_q <= txd;
      run <= (txd != txd_q) ? 16'h0000 : ((run == 16'hFFFF) ? run : run + 16'h0001);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // bus and line checks
  // ----------------------------------------
  one_wait_a: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_unmapped_a: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  err_read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("prdata moved outside a read");
  xfer_byte_a: assert property (pready && !pwrite && paddr < EMFP_CTRL_ADDR
    |-> prdata[31:8] == 24'h0)
    else $error("transfer byte read wider than a byte");
  bit_time_a: assert property (txd != txd_q |-> run >= BIT_CYCLES - 1)
    else $error("serial bit shorter than bit time");
  irq_masked_a: assert property (pready && pwrite && paddr == EMFP_MASK_ADDR
    && pwdata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("irq high with mask cleared");
  cover property (pready && pslverr);
  cover property (txd != txd_q);
  cover property ($rose(irq));
endmodule // emfp_printer_assertions

bind emfp_printer emfp_printer_assertions #(.BIT_CYCLES(BIT_CYCLES)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .txd(txd));

// ==== bench/error_message_frame_printer_tb.sv ====
`timescale 1ns/1ns
module error_message_frame_printer_tb
  import emfp_pkg::*;
;
  localparam int BITC = 4;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, irq, txd, rx_stb, rx_bad, err;
  logic [7:0] rx_char;
  logic [31:0] rng = 32'h86CEA09A;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  logic [7:0] rxq[$];
  logic [15:0] badw[3] = '{16'h5F01, 16'h4F00, 16'h4F10};
  emfp_frame_t fr, fr2;
  always #5 pclk = ~pclk;
  emfp_printer #(.BIT_CYCLES(BITC)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .txd(txd));
  emfp_printer_model #(.BIT_CYCLES(BITC)) printer (.pclk(pclk), .txd(txd),
    .rx_char(rx_char), .rx_stb(rx_stb), .rx_bad(rx_bad));
  task finish_test();
    $display("compares %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask
  // collect characters; a hang ends the run as a mismatch
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (rx_stb === 1'b1)
    begin
      rxq.push_back(rx_char);
      check("char framing", 32'h0, {31'h0, rx_bad});
    end
    if (cyc > 80000)
    begin
      bad_count++;
      finish_test();
    end
  end
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // stored text expected for each text number, first character in the top byte
  function automatic logic [127:0] txt(input logic [11:0] t);
    logic [127:0] s[15];
    s = '{"CPU ERROR       ", "CPU/IF ERROR    ", "USER MEM ERROR  ", "FW EPROM ERROR  ",
      "BATTERY FAULT   ", "LAN ERROR       ", "WARM RESTART ERR", "POWER OFF       ",
      "STOP SWITCHED   ", "HANDLING ERROR  ", "I/O ERROR DIG IN", "I/O ERROR DQ    ",
      "I/O ERROR ANALOG", "TIMEOUT         ", "CANNOT EVALUATE "};
    return s[t - EMFP_TEXT_FIRST];
  endfunction
  // frame for a text number with fields of the right kind
  function automatic emfp_frame_t make(input logic [11:0] t);
    emfp_frame_t f;
    f.w1 = {EMFP_JOB_NUMBER, t};
    f.w2 = 16'(rnd());
    f.w3 = 16'h0000;
    f.w4 = 16'(rnd());
    if (t == EMFP_TEXT_TIMEOUT)
    begin
      f.w2 = EMFP_MODTYPE_BASE + 16'(rnd() % 5);
      f.w3 = rnd() % 2 ? 16'h00FF : 16'(rnd() % 256);
    end
    else if (t == EMFP_TEXT_LAN)
    begin
      f.w3 = 16'h0041 + 16'(rnd() % 2);
      f.w4 = 16'h0000;
    end
    else if (t >= EMFP_TEXT_IO_FIRST && t <= EMFP_TEXT_IO_LAST)
      f.w3 = EMFP_GROUP_BASE + 16'(rnd() % 32);
    return f;
  endfunction
  // apb transfer: setup, access, hold until ready, release
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && ++n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      bad_count++;
      finish_test();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0, rd, err);
    check(nm, exp, rd);
  endtask
  // eight bytes in wrapping order, starting at a random offset
  task send(input emfp_frame_t f);
    logic [63:0] b;
    int s;
    b = f;
    s = rnd() % 8;
    for (int k = 0; k < 8; k++)
      wr(8'(4 * ((k + s) % 8)), {24'h0, b[63 - 8 * ((k + s) % 8) -: 8]});
  endtask
  task check_line(input emfp_frame_t f);
    logic [7:0] a, b, c;
    logic [7:0] e[16];
    logic [127:0] ts;
    int n;
    ts = txt(f.w1[11:0]);
    a = f.w2[15:8];
    b = f.w2[7:0];
    c = f.w3[7:0];
    if (f.w1[11:0] == EMFP_TEXT_TIMEOUT)
      {a, b, c} = {8'(f.w2 - EMFP_MODTYPE_BASE), f.w3[7:0], 8'h00};
    else if (f.w1[11:0] >= EMFP_TEXT_IO_FIRST && f.w1[11:0] <= EMFP_TEXT_IO_LAST)
      c = 8'(f.w3 - EMFP_GROUP_BASE);
    e = '{EMFP_SPACE, hx(a[7:4]), hx(a[3:0]), EMFP_COMMA, hx(b[7:4]), hx(b[3:0]), EMFP_SPACE,
      hx(c[7:4]), hx(c[3:0]), EMFP_SPACE, hx(f.w4[15:12]), hx(f.w4[11:8]), EMFP_COMMA,
      hx(f.w4[7:4]), hx(f.w4[3:0]), EMFP_SPACE};
    n = 0;
    while (rxq.size() < 33 && n++ < 3000)
      @(posedge pclk);
    check("line length", 32'h1, {31'h0, rxq.size() >= 33});
    for (int i = 0; i < 16; i++)
      check("text char", {24'h0, ts[127 - 8 * i -: 8]}, {24'h0, rxq[i]});
    for (int i = 0; i < 16; i++)
      check("param char", {24'h0, e[i]}, {24'h0, rxq[16 + i]});
    check("end code", {24'h0, EMFP_CR_CODE}, {24'h0, rxq[32]});
    for (int i = 0; i < 32; i++)
      check("no line feed", 32'h0, {31'h0, rxq[i] == EMFP_LF_CODE});
    repeat (33) void'(rxq.pop_front());
    repeat (BITC) @(posedge pclk);
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(EMFP_CTRL_ADDR, 32'h1, "ctrl reset");
    rdc(EMFP_STAT_ADDR, 32'h0, "status reset");
    rdc(EMFP_MASK_ADDR, 32'h0, "mask reset");
    rdc(8'h1C, 32'h0, "transfer reset");
    rdc(8'h30, 32'h0, "unmapped data");
    check("unmapped err", 32'h1, {31'h0, err});
    wr(EMFP_MASK_ADDR, 32'h3);
    // every text number once, random parameter words
    for (int t = 3841; t <= 3855; t++)
    begin
      fr = make(12'(t));
      send(fr);
      if (t == 3846)
      begin
        rdc(8'h00, {24'h0, fr.w1[15:8]}, "refresh keep");
        rdc(8'h0C, 32'h5, "refresh count");
        rdc(8'h10, 32'h0, "refresh clear");
      end
      check_line(fr);
      rdc(EMFP_STAT_ADDR, 32'h1, "status done");
      check("irq set", 32'h1, {31'h0, irq});
      wr(EMFP_STAT_ADDR, 32'h1);
    end
    rdc(EMFP_INFO_ADDR, 32'hF, "line count");
    // second frame written while the first prints
    fr = make(EMFP_TEXT_LAN);
    fr2 = make(EMFP_TEXT_TIMEOUT);
    send(fr);
    send(fr2);
    check_line(fr);
    check_line(fr2);
    // disabled block holds the frame until enabled
    wr(EMFP_CTRL_ADDR, 32'h0);
    fr = make(EMFP_TEXT_IO_LAST);
    send(fr);
    repeat (40) @(posedge pclk);
    check("disabled silent", 32'h0, rxq.size());
    wr(EMFP_CTRL_ADDR, 32'h1);
    check_line(fr);
    wr(EMFP_STAT_ADDR, 32'h3);
    // bad job number and unknown texts
    for (int i = 0; i < 3; i++)
    begin
      fr = make(12'h0);
      fr.w1 = badw[i];
      send(fr);
      repeat (40) @(posedge pclk);
      check("reject silent", 32'h0, rxq.size());
      rdc(EMFP_STAT_ADDR, 32'h2, "status reject");
    end
    check("irq reject", 32'h1, {31'h0, irq});
    wr(EMFP_MASK_ADDR, 32'h0);
    rdc(EMFP_INFO_ADDR, 32'h12, "count after reject");
    check("irq masked", 32'h0, {31'h0, irq});
    finish_test();
  end
endmodule // error_message_frame_printer_tb
